/* File: inc/pif_map.svh */
// register offsets, field positions, reset values for the peripheral flag block
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH
`define PIF_OFF_FLAGS 12'h000
`define PIF_OFF_ENABLE 12'h004
`define PIF_OFF_CONTROL 12'h008
`define PIF_OFF_PENDING 12'h00C
`define PIF_BIT_FIRST_TIMER 0
`define PIF_BIT_SECOND_TIMER 1
`define PIF_BIT_CAPTURE 2
`define PIF_BIT_SYNC_SERIAL 3
`define PIF_BIT_SERIAL_TX 4
`define PIF_BIT_SERIAL_RX 5
`define PIF_BIT_CONVERTER 6
`define PIF_BIT_PARALLEL 7
`define PIF_BIT_GLOBAL_EN 7
`define PIF_BIT_PERIPH_EN 6
`define PIF_RESET_FLAGS 8'h00
`define PIF_RESET_ENABLE 8'h00
`define PIF_RESET_CONTROL 8'h00
`define PIF_SW_CLEAR_MASK 8'hCF
`endif

/* File: inc/pif_pkg.sv */
// types for the peripheral flag block
package pif_pkg;
  typedef struct packed {
    logic parallelDone;
    logic converterDone;
    logic rxHasData;
    logic txEmpty;
    logic syncSerialEvent;
    logic captureEvent;
    logic secondTimerMatch;
    logic firstTimerOverflow;
  } pif_events_type;
endpackage

/* File: logic/pif_flag_register.sv */
// peripheral interrupt flag register with apb slave and interrupt output
// What this block does
// - Each flag is set on its source event regardless of any enable bit.
// - Eight flags sit in one register, parallel port at bit 7 down to first timer at bit 0.
// - The converter flag is set when a conversion finishes; zero means none pending.
// - The receive flag follows the receive buffer being non-empty and is read-only.
// - The transmit flag is high while the transmit buffer is empty and is read-only.
// - The global enable, with the peripheral enable also set, lets unmasked sources interrupt and blocks all when clear.
// - The capture flag is set on a timer capture and stays until software clears it.
`timescale 1ns/1ps
`include "pif_map.svh"
module pif_flag_register #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pif_pkg::pif_events_type events,
  output logic irq
);

  // offsets are 12-bit constants; a wider bus would need them extended
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 12) begin : g_width_check
    $error("address width outside what the register map decodes");
  end

  // ****************
  // flags and registers
  // ****************
  logic [7:0] flags;
  logic [7:0] enable;
  logic [7:0] control;
  logic [7:0] eventVec;
  logic [7:0] pending;
  logic wrAccess;
  logic rdAccess;
  logic lowLane;
  logic hitFlags;
  logic hitEnable;
  logic hitControl;
  logic hitPending;
  logic wrFlags;
  logic wrEnable;
  logic wrControl;
  logic [7:0] swClear;
  logic [7:0] stickyEvents;

  assign eventVec = events;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign lowLane = pstrb[0];
  assign pready = 1'b1;

  function automatic logic decodeHit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] off);
    decodeHit = (a == off[ADDR_WIDTH-1:0]);
  endfunction

  // ****************
  // bus decode
  // ****************
  assign hitFlags = decodeHit(paddr, `PIF_OFF_FLAGS);
  assign hitEnable = decodeHit(paddr, `PIF_OFF_ENABLE);
  assign hitControl = decodeHit(paddr, `PIF_OFF_CONTROL);
  assign hitPending = decodeHit(paddr, `PIF_OFF_PENDING);
  assign wrFlags = wrAccess & lowLane & hitFlags;
  assign wrEnable = wrAccess & lowLane & hitEnable;
  assign wrControl = wrAccess & lowLane & hitControl;
  // receive and transmit bits are outside the mask, so writes never touch them
  assign swClear = wrFlags ? (pwdata[7:0] & `PIF_SW_CLEAR_MASK) : 8'h00;
  assign stickyEvents = eventVec & `PIF_SW_CLEAR_MASK;

  // write-one-to-clear; a source event in the same cycle wins over the clear
  // buffer-state flags bypass this: they are plain copies of the buffer status
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags <= `PIF_RESET_FLAGS;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == `PIF_BIT_SERIAL_RX || i == `PIF_BIT_SERIAL_TX) begin
          flags[i] <= eventVec[i];
        end else if (eventVec[i]) begin
          flags[i] <= 1'b1;
        end else if (swClear[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable <= `PIF_RESET_ENABLE;
    end else if (wrEnable) begin
      enable <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      control <= `PIF_RESET_CONTROL;
    end else if (wrControl) begin
      control <= pwdata[7:0] & 8'hC0;
    end
  end

  // ****************
  // interrupt output
  // ****************
  assign pending = flags & enable;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= control[`PIF_BIT_GLOBAL_EN] & control[`PIF_BIT_PERIPH_EN] & (|pending);
    end
  end

  // ****************
  // read path
  // ****************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (decodeHit(paddr, `PIF_OFF_FLAGS)) begin
        prdata <= {24'h000000, flags};
      end else if (decodeHit(paddr, `PIF_OFF_ENABLE)) begin
        prdata <= {24'h000000, enable};
      end else if (decodeHit(paddr, `PIF_OFF_CONTROL)) begin
        prdata <= {24'h000000, control};
      end else if (decodeHit(paddr, `PIF_OFF_PENDING)) begin
        prdata <= {24'h000000, pending};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(decodeHit(paddr, `PIF_OFF_FLAGS) || decodeHit(paddr, `PIF_OFF_ENABLE)
                 || decodeHit(paddr, `PIF_OFF_CONTROL)
                 || (decodeHit(paddr, `PIF_OFF_PENDING) && !pwrite));
    end
  end

  // ****************
  // checks
  // ****************
  sequence s_access;
    psel && penable;
  endsequence

  sequence s_setup_rd_flags;
    psel && !penable && !pwrite && hitFlags;
  endsequence

  sequence s_wr_enable;
    psel && penable && pwrite && lowLane && hitEnable;
  endsequence

  sequence s_wr_control;
    psel && penable && pwrite && lowLane && hitControl;
  endsequence

  property p_rd_flags;
    @(posedge clk_sys) disable iff (srst)
      s_setup_rd_flags ##1 s_access |-> prdata == {24'h000000, $past(flags)};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read data wrong");

  property p_rd_stable;
    @(posedge clk_sys) disable iff (srst)
      rdAccess |=> $stable(prdata);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");

  property p_wr_enable;
    @(posedge clk_sys) disable iff (srst)
      s_wr_enable |=> enable == $past(pwdata[7:0]);
  endproperty
  a_wr_enable: assert property (p_wr_enable) else $error("mask write lost");

  property p_wr_control;
    @(posedge clk_sys) disable iff (srst)
      s_wr_control |=> control == {$past(pwdata[`PIF_BIT_GLOBAL_EN]),
                                   $past(pwdata[`PIF_BIT_PERIPH_EN]), 6'h00};
  endproperty
  a_wr_control: assert property (p_wr_control) else $error("control write lost");

  property p_set_any;
    @(posedge clk_sys) disable iff (srst)
      |stickyEvents |=> (flags & $past(stickyEvents)) == $past(stickyEvents);
  endproperty
  a_set_any: assert property (p_set_any) else $error("event flag not set");

  property p_clear;
    @(posedge clk_sys) disable iff (srst)
      |(swClear & ~eventVec) |=> (flags & $past(swClear & ~eventVec)) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_rx_ro;
    @(posedge clk_sys) disable iff (srst)
      wrFlags && pwdata[`PIF_BIT_SERIAL_RX] && events.rxHasData
        |=> flags[`PIF_BIT_SERIAL_RX];
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("receive flag written");

  property p_tx_ro;
    @(posedge clk_sys) disable iff (srst)
      wrFlags && pwdata[`PIF_BIT_SERIAL_TX] && events.txEmpty
        |=> flags[`PIF_BIT_SERIAL_TX];
  endproperty
  a_tx_ro: assert property (p_tx_ro) else $error("transmit flag written");

  property p_err_unmapped;
    @(posedge clk_sys) disable iff (srst)
      s_access ##0 !(hitFlags || hitEnable || hitControl || hitPending) |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

  property p_err_pending_wr;
    @(posedge clk_sys) disable iff (srst)
      s_access ##0 (pwrite && hitPending) |-> pslverr;
  endproperty
  a_err_pending_wr: assert property (p_err_pending_wr) else $error("pending write taken");

  property p_no_err;
    @(posedge clk_sys) disable iff (srst)
      s_access ##0 (hitFlags || hitEnable || hitControl) |-> !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("mapped access refused");

  property p_masked;
    @(posedge clk_sys) disable iff (srst)
      pending == 8'h00 |=> !irq;
  endproperty
  a_masked: assert property (p_masked) else $error("irq with nothing pending");

  property p_latch_event;
    @(posedge clk_sys) disable iff (srst)
      events.captureEvent |=> flags[`PIF_BIT_CAPTURE];
  endproperty
  a_latch_event: assert property (p_latch_event) else $error("capture flag not set");

  property p_sticky_cap;
    @(posedge clk_sys) disable iff (srst)
      flags[`PIF_BIT_CAPTURE] && !(wrAccess && pwdata[`PIF_BIT_CAPTURE])
        |=> flags[`PIF_BIT_CAPTURE];
  endproperty
  a_sticky_cap: assert property (p_sticky_cap) else $error("capture flag lost");

  property p_conv;
    @(posedge clk_sys) disable iff (srst)
      events.converterDone |=> flags[`PIF_BIT_CONVERTER];
  endproperty
  a_conv: assert property (p_conv) else $error("converter flag not set");

  property p_rx;
    @(posedge clk_sys) disable iff (srst)
      1'b1 |=> flags[`PIF_BIT_SERIAL_RX] == $past(events.rxHasData);
  endproperty
  a_rx: assert property (p_rx) else $error("receive flag wrong");

  property p_tx;
    @(posedge clk_sys) disable iff (srst)
      1'b1 |=> flags[`PIF_BIT_SERIAL_TX] == $past(events.txEmpty);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit flag wrong");

  property p_par;
    @(posedge clk_sys) disable iff (srst)
      events.parallelDone ##1 !wrAccess |=> flags[`PIF_BIT_PARALLEL];
  endproperty
  a_par: assert property (p_par) else $error("parallel flag not held");

  property p_gate;
    @(posedge clk_sys) disable iff (srst)
      !control[`PIF_BIT_GLOBAL_EN] |=> !irq;
  endproperty
  a_gate: assert property (p_gate) else $error("irq while globally disabled");

  property p_fire;
    @(posedge clk_sys) disable iff (srst)
      control[`PIF_BIT_GLOBAL_EN] && control[`PIF_BIT_PERIPH_EN] && (|pending) |=> irq;
  endproperty
  a_fire: assert property (p_fire) else $error("irq missing");

  property p_layout;
    @(posedge clk_sys) disable iff (srst)
      events.firstTimerOverflow |=> flags[0];
  endproperty
  a_layout: assert property (p_layout) else $error("first timer not at bit 0");

endmodule

/* File: tb/pif_flag_register_tb_top.sv */
// self-checking bench for the peripheral flag register
`timescale 1ns/1ps
`include "pif_map.svh"
module pif_flag_register_tb_top;
  // ********************
  // signals and clock
  // ********************
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  pif_pkg::pif_events_type ev = '0;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  pif_flag_register u_dut (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(ev), .irq(irq));
  // ********************
  // shared tasks
  // ********************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ceiling well above the roughly two hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_sys);
    ev <= pif_pkg::pif_events_type'(v);
    @(posedge clk_sys);
    ev <= '0;
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    chk("irq at reset", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask
  task automatic t_sticky();
    for (int i = 0; i < 8; i++) begin
      if (i != 4 && i != 5) begin
        pulse(8'(1 << i));
        apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
        chk("flag position", 32'(1 << i), rd);
        apb(1'b1, `PIF_OFF_FLAGS, 32'(1 << i));
        apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
        chk("flag cleared", 32'h0, rd);
      end
    end
    $display("test sticky done");
  endtask
  task automatic t_levels();
    @(posedge clk_sys);
    ev.rxHasData <= 1'b1;
    apb(1'b1, `PIF_OFF_FLAGS, 32'h000000FF);
    apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
    chk("rx level", 32'h20, rd);
    ev.rxHasData <= 1'b0;
    ev.txEmpty <= 1'b1;
    apb(1'b1, `PIF_OFF_FLAGS, 32'h000000FF);
    apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
    chk("tx level", 32'h10, rd);
    ev.txEmpty <= 1'b0;
    $display("test levels done");
  endtask
  task automatic t_irq();
    apb(1'b1, `PIF_OFF_FLAGS, 32'h000000FF);
    apb(1'b1, `PIF_OFF_ENABLE, 32'h00000040);
    apb(1'b1, `PIF_OFF_CONTROL, 32'h00000040);
    pulse(8'h40);
    repeat (2) @(posedge clk_sys);
    chk("irq global off", 32'h0, {31'h0, irq});
    apb(1'b1, `PIF_OFF_CONTROL, 32'h000000C0);
    repeat (2) @(posedge clk_sys);
    chk("irq global on", 32'h1, {31'h0, irq});
    apb(1'b1, `PIF_OFF_FLAGS, 32'h00000040);
    repeat (2) @(posedge clk_sys);
    chk("irq after clear", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test irq done");
  endtask
  task automatic t_more();
    @(posedge clk_sys);
    ev.captureEvent <= 1'b1;
    apb(1'b1, `PIF_OFF_FLAGS, 32'h00000004);
    ev.captureEvent <= 1'b0;
    apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
    chk("event beats clear", 32'h04, rd);
    apb(1'b1, `PIF_OFF_FLAGS, 32'h00000004);
    pulse(8'h01);
    apb(1'b0, `PIF_OFF_PENDING, 32'h0);
    chk("masked pending", 32'h0, rd);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, `PIF_OFF_ENABLE, 32'h00000041);
    apb(1'b0, `PIF_OFF_PENDING, 32'h0);
    chk("unmasked pending", 32'h01, rd);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    apb(1'b1, `PIF_OFF_CONTROL, 32'h000000FF);
    apb(1'b0, `PIF_OFF_CONTROL, 32'h0);
    chk("control bits", 32'hC0, rd);
    chk("mapped error", 32'h0, {31'h0, err});
    apb(1'b1, `PIF_OFF_CONTROL, 32'h00000080);
    repeat (2) @(posedge clk_sys);
    chk("irq peripheral off", 32'h0, {31'h0, irq});
    apb(1'b1, `PIF_OFF_PENDING, 32'h0);
    chk("pending write error", 32'h1, {31'h0, err});
    @(posedge clk_sys);
    pstrb <= 4'h0;
    apb(1'b1, `PIF_OFF_ENABLE, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, `PIF_OFF_ENABLE, 32'h0);
    chk("strobe-less write", 32'h41, rd);
    apb(1'b0, `PIF_OFF_FLAGS, 32'h0);
    chk("flag kept", 32'h01, rd);
    $display("test more done");
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_sticky();
    t_levels();
    t_irq();
    t_more();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    stop_test();
  end
endmodule
